// [verilog/dgp_pkg.sv]
// shared constants for the dual port pin bank
package dgp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] DGP_IDX_ACT = 8'h30;
   localparam logic [7:0] DGP_IDX_DIR1 = 8'he0;
   localparam logic [7:0] DGP_IDX_DAT1 = 8'he1;
   localparam logic [7:0] DGP_IDX_POL1 = 8'he2;
   localparam logic [7:0] DGP_IDX_STS1 = 8'he3;
   localparam logic [7:0] DGP_IDX_DIR2 = 8'he4;
   localparam logic [7:0] DGP_IDX_DAT2 = 8'he5;
   localparam logic [7:0] DGP_IDX_POL2 = 8'he6;
   localparam logic [7:0] DGP_IDX_STS2 = 8'he7;
   // interrupt mask registers, same layout as the status registers
   localparam logic [7:0] DGP_IDX_MSK1 = 8'hf0;
   localparam logic [7:0] DGP_IDX_MSK2 = 8'hf1;
   // activation field positions
   localparam int DGP_ACT_FIRST_BIT = 0;
   localparam int DGP_ACT_SECOND_BIT = 1;
   // reset values
   localparam logic [1:0] DGP_RST_ACT = 2'h3;
   localparam logic [7:0] DGP_RST_DIR = 8'hff;
   localparam logic [7:0] DGP_RST_DAT = 8'h00;
   localparam logic [7:0] DGP_RST_POL = 8'h00;
   localparam logic [7:0] DGP_RST_STS = 8'h00;
   localparam logic [7:0] DGP_RST_MSK = 8'h00;
   // pin counts
   localparam int DGP_FIRST_PINS = 8;
   localparam int DGP_SECOND_PINS = 5;
   // bus widths
   localparam int DGP_ADDR_W = 12;
   localparam int DGP_DATA_W = 32;
endpackage : dgp_pkg

// [verilog/dgp_gpio_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module dgp_gpio_bank
   import dgp_pkg::*;
#(
   parameter int N1 = DGP_FIRST_PINS,
   parameter int N2 = DGP_SECOND_PINS
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DGP_ADDR_W-1:0] paddr,
   input wire logic [DGP_DATA_W-1:0] pwdata,
   output logic [DGP_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // first port pins
   input wire logic [N1-1:0] firstPinsIn,
   output logic [N1-1:0] firstPinsOut,
   output logic [N1-1:0] firstPinsOeN,
   // second port pins
   input wire logic [N2-1:0] secondPinsIn,
   output logic [N2-1:0] secondPinsOut,
   output logic [N2-1:0] secondPinsOeN,
   // level interrupt
   output logic irq
);
   // whole state of the block
   typedef struct packed {
      // port enables, bit0 first port, bit1 second port
      logic [1:0] act;
      // first port configuration and event bits
      logic [N1-1:0] dir1; // 1 = input
      logic [N1-1:0] dat1; // stored output data
      logic [N1-1:0] pol1; // 1 = inverted pin
      logic [N1-1:0] sts1; // sticky edge events
      logic [N1-1:0] msk1; // interrupt enables
      // second port configuration and event bits
      logic [N2-1:0] dir2; // 1 = input
      logic [N2-1:0] dat2; // stored output data
      logic [N2-1:0] pol2; // 1 = inverted pin
      logic [N2-1:0] sts2; // sticky edge events
      logic [N2-1:0] msk2; // interrupt enables
      // pin input pipeline
      logic [N1-1:0] syncA1; // first sync stage, port 1
      logic [N1-1:0] syncB1; // second sync stage, port 1
      logic [N1-1:0] prev1; // last synced level, port 1
      logic [N2-1:0] syncA2;
      logic [N2-1:0] syncB2;
      logic [N2-1:0] prev2;
      logic [N1-1:0] out1; // pin drive registers
      logic [N1-1:0] oeN1;
      logic [N2-1:0] out2;
      logic [N2-1:0] oeN2;
      // bus answer and interrupt registers
      logic [DGP_DATA_W-1:0] rdata;
      logic ready;
      logic slverr;
      logic irq;
   } dgp_state_t;

   dgp_state_t st_q;
   dgp_state_t st_d;

   // bus decode helpers
   logic [7:0] idx;
   logic setupPh;
   logic accRd;
   logic accWr;
   logic hit;
   logic [7:0] wByte;
   // pin levels seen as data bits
   logic [N1-1:0] view1;
   logic [N2-1:0] view2;
   // edge events
   logic [N1-1:0] ev1;
   logic [N2-1:0] ev2;
   // read value of the addressed register
   logic [7:0] rByte;

   // address and phase decode
   // the word index drops the two byte bits; upper bits must be zero
   always_comb begin
      // register index of the transfer
      idx = paddr[9:2];
      // only the low byte carries register data
      wByte = pwdata[7:0];
      // setup cycle: select without enable
      setupPh = psel & ~penable;
      // access cycles complete on the single ready cycle
      accRd = psel & penable & st_q.ready & ~pwrite;
      accWr = psel & penable & st_q.ready & pwrite;
      hit = (paddr[DGP_ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0) &&
            (idx == DGP_IDX_ACT || idx == DGP_IDX_DIR1 || idx == DGP_IDX_DAT1 ||
             idx == DGP_IDX_POL1 || idx == DGP_IDX_STS1 || idx == DGP_IDX_DIR2 ||
             idx == DGP_IDX_DAT2 || idx == DGP_IDX_POL2 || idx == DGP_IDX_STS2 ||
             idx == DGP_IDX_MSK1 || idx == DGP_IDX_MSK2);
   end

   // data view: outputs read stored bits, inputs read synced pins
   always_comb begin
      view1 = (st_q.dir1 & (st_q.syncB1 ^ st_q.pol1)) | (~st_q.dir1 & st_q.dat1);
      view2 = (st_q.dir2 & (st_q.syncB2 ^ st_q.pol2)) | (~st_q.dir2 & st_q.dat2);
   end

   // edge detection on synced levels, only while the port is active
   always_comb begin
      ev1 = (st_q.syncB1 ^ st_q.prev1) & {N1{st_q.act[DGP_ACT_FIRST_BIT]}};
      ev2 = (st_q.syncB2 ^ st_q.prev2) & {N2{st_q.act[DGP_ACT_SECOND_BIT]}};
   end

   // read mux, narrow registers zero extended
   always_comb begin
      rByte = 8'h00;
      case (idx)
         DGP_IDX_ACT: begin
            // reserved upper bits read zero
            rByte = {6'h00, st_q.act};
         end
         DGP_IDX_DIR1: begin
            // first port direction
            rByte = 8'(st_q.dir1);
         end
         DGP_IDX_DAT1: begin
            // first port data view, mixed stored and pin bits
            rByte = 8'(view1);
         end
         DGP_IDX_POL1: begin
            // first port polarity
            rByte = 8'(st_q.pol1);
         end
         DGP_IDX_STS1: begin
            // first port events, cleared by this read
            rByte = 8'(st_q.sts1);
         end
         DGP_IDX_MSK1: begin
            // first port interrupt mask
            rByte = 8'(st_q.msk1);
         end
         DGP_IDX_DIR2: begin
            // second port direction, upper bits zero
            rByte = 8'(st_q.dir2);
         end
         DGP_IDX_DAT2: begin
            // second port data view
            rByte = 8'(view2);
         end
         DGP_IDX_POL2: begin
            // second port polarity
            rByte = 8'(st_q.pol2);
         end
         DGP_IDX_STS2: begin
            // second port events, only five bits exist
            rByte = 8'(st_q.sts2);
         end
         DGP_IDX_MSK2: begin
            // second port interrupt mask
            rByte = 8'(st_q.msk2);
         end
         default: begin
            // unmapped index reads zero
            rByte = 8'h00;
         end
      endcase
   end

   // next state
   always_comb begin
      st_d = st_q;
      // pin synchronisers, first stage read only by the second
      st_d.syncA1 = firstPinsIn;
      st_d.syncB1 = st_q.syncA1;
      st_d.prev1 = st_q.syncB1;
      st_d.syncA2 = secondPinsIn;
      st_d.syncB2 = st_q.syncA2;
      st_d.prev2 = st_q.syncB2;
      // answer is prepared in the setup cycle; zero wait states
      st_d.ready = setupPh;
      st_d.slverr = setupPh & ~hit;
      if (setupPh) begin
         st_d.rdata = hit ? {24'h000000, rByte} : '0;
      end
      // status: clear only bits returned by this read, new events win
      if (accRd && hit && idx == DGP_IDX_STS1) begin
         st_d.sts1 = st_q.sts1 & ~st_q.rdata[N1-1:0];
      end
      if (accRd && hit && idx == DGP_IDX_STS2) begin
         st_d.sts2 = st_q.sts2 & ~st_q.rdata[N2-1:0];
      end
      st_d.sts1 = st_d.sts1 | ev1;
      st_d.sts2 = st_d.sts2 | ev2;
      // register writes take effect at the completing edge
      if (accWr && hit) begin
         case (idx)
            DGP_IDX_ACT: begin
               // reserved bits are dropped
               st_d.act = wByte[1:0];
            end
            DGP_IDX_DIR1: begin
               // new directions drive the pin enables at this same edge
               st_d.dir1 = wByte[N1-1:0];
            end
            DGP_IDX_DAT1: begin
               // input bits keep their stored value
               st_d.dat1 = (st_q.dat1 & st_q.dir1) | (wByte[N1-1:0] & ~st_q.dir1);
            end
            DGP_IDX_POL1: begin
               // polarity applies to inputs and outputs alike
               st_d.pol1 = wByte[N1-1:0];
            end
            DGP_IDX_MSK1: begin
               // mask only gates the interrupt, not the status
               st_d.msk1 = wByte[N1-1:0];
            end
            DGP_IDX_DIR2: begin
               // upper written bits have no pin and are dropped
               st_d.dir2 = wByte[N2-1:0];
            end
            DGP_IDX_DAT2: begin
               // input bits keep their stored value
               st_d.dat2 = (st_q.dat2 & st_q.dir2) | (wByte[N2-1:0] & ~st_q.dir2);
            end
            DGP_IDX_POL2: begin
               // polarity applies to inputs and outputs alike
               st_d.pol2 = wByte[N2-1:0];
            end
            DGP_IDX_MSK2: begin
               // mask only gates the interrupt, not the status
               st_d.msk2 = wByte[N2-1:0];
            end
            default: begin
               // status registers are read only
            end
         endcase
      end
      // pin drive: only active ports drive their output pins
      st_d.out1 = st_d.dat1 ^ st_d.pol1;
      st_d.oeN1 = st_d.dir1 | {N1{~st_d.act[DGP_ACT_FIRST_BIT]}};
      st_d.out2 = st_d.dat2 ^ st_d.pol2;
      st_d.oeN2 = st_d.dir2 | {N2{~st_d.act[DGP_ACT_SECOND_BIT]}};
      // level interrupt from masked status
      st_d.irq = |(st_d.sts1 & st_d.msk1) | |(st_d.sts2 & st_d.msk2);
   end

   // state register
   // reset holds every pin released and the bus answer idle;
   // the sync stages reset low, so a pin held low gives no false edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // clear everything first, then load documented defaults
         st_q <= '0;
         st_q.act <= DGP_RST_ACT;
         st_q.dir1 <= DGP_RST_DIR[N1-1:0];
         st_q.dat1 <= DGP_RST_DAT[N1-1:0];
         st_q.pol1 <= DGP_RST_POL[N1-1:0];
         st_q.sts1 <= DGP_RST_STS[N1-1:0];
         st_q.msk1 <= DGP_RST_MSK[N1-1:0];
         st_q.dir2 <= DGP_RST_DIR[N2-1:0];
         st_q.dat2 <= DGP_RST_DAT[N2-1:0];
         st_q.pol2 <= DGP_RST_POL[N2-1:0];
         st_q.sts2 <= DGP_RST_STS[N2-1:0];
         st_q.msk2 <= DGP_RST_MSK[N2-1:0];
         // all pins start as inputs, so no driver is enabled
         st_q.oeN1 <= '1;
         st_q.oeN2 <= '1;
      end else begin
         // whole state moves together every edge
         st_q <= st_d;
      end
   end

   // outputs straight from flops
   // no logic between the state register and the ports
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slverr;
   assign firstPinsOut = st_q.out1;
   assign firstPinsOeN = st_q.oeN1;
   assign secondPinsOut = st_q.out2;
   assign secondPinsOeN = st_q.oeN2;
   assign irq = st_q.irq;
endmodule : dgp_gpio_bank
`default_nettype wire

// [testbench/dgp_gpio_bank_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dgp_gpio_bank_asserts
   import dgp_pkg::*;
#(
   parameter int N1 = DGP_FIRST_PINS,
   parameter int N2 = DGP_SECOND_PINS
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DGP_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N1-1:0] firstPinsIn,
   input wire logic [N1-1:0] firstPinsOut,
   input wire logic [N1-1:0] firstPinsOeN,
   input wire logic [N2-1:0] secondPinsIn,
   input wire logic [N2-1:0] secondPinsOut,
   input wire logic [N2-1:0] secondPinsOeN,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // setup phase of a transfer
   sequence s_setup;
      psel && !penable;
   endsequence
   a_ready_follows: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   // pin drive only moves after a completed write
   a_out_by_write: assert property ($changed({firstPinsOut, secondPinsOut})
      |-> $past(psel && penable && pwrite))
      else $error("pin drive changed without write");
   a_oe_by_write: assert property ($changed({firstPinsOeN, secondPinsOeN})
      |-> $past(psel && penable && pwrite))
      else $error("pin enable changed without write");
   a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable))
      else $error("irq dropped without access");
   // a rise needs a write or a pin change three edges back
   a_irq_rise: assert property ($rose(irq) |-> $past(psel && penable && pwrite)
      || $past(firstPinsIn, 3) != $past(firstPinsIn, 4)
      || $past(secondPinsIn, 3) != $past(secondPinsIn, 4))
      else $error("irq rose without cause");
endmodule : dgp_gpio_bank_asserts
bind dgp_gpio_bank dgp_gpio_bank_asserts #(.N1(N1), .N2(N2)) chk_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .firstPinsIn(firstPinsIn),
   .firstPinsOut(firstPinsOut), .firstPinsOeN(firstPinsOeN), .secondPinsIn(secondPinsIn),
   .secondPinsOut(secondPinsOut), .secondPinsOeN(secondPinsOeN), .irq(irq));
`default_nettype wire

// [testbench/dgp_pin_board.sv]
`timescale 1ns/1ps
`default_nettype none
// board side: holds each pin at its level unless the bank drives it
module dgp_pin_board (
   input wire logic [7:0] lvl1,
   input wire logic [4:0] lvl2,
   input wire logic [7:0] out1,
   input wire logic [7:0] oeN1,
   input wire logic [4:0] out2,
   input wire logic [4:0] oeN2,
   output logic [7:0] pin1,
   output logic [4:0] pin2
);
   // an enabled bank driver wins the wire
   assign pin1 = (out1 & ~oeN1) | (lvl1 & oeN1);
   assign pin2 = (out2 & ~oeN2) | (lvl2 & oeN2);
endmodule : dgp_pin_board
`default_nettype wire

// [testbench/tb_dual_gpio_port_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dual_gpio_port_bank
   import dgp_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rst_n, psel, penable, pwrite, pready, pslverr, irq, errv;
   logic [DGP_ADDR_W-1:0] paddr;
   logic [DGP_DATA_W-1:0] pwdata, prdata, rdv;
   logic [7:0] pin1, out1, oeN1;
   logic [4:0] pin2, out2, oeN2;
   logic [7:0] brd [2]; // board levels per port
   int bad_count = 0, checks = 0, seed = 91375;
   dgp_gpio_bank uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .firstPinsIn(pin1), .firstPinsOut(out1), .firstPinsOeN(oeN1),
      .secondPinsIn(pin2), .secondPinsOut(out2), .secondPinsOeN(oeN2), .irq(irq));
   dgp_pin_board board (.lvl1(brd[0]), .lvl2(brd[1][4:0]), .out1(out1), .oeN1(oeN1),
      .out2(out2), .oeN2(oeN2), .pin1(pin1), .pin2(pin2));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer, held until pready, then one idle edge
   task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, ix, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a transfer that never completes is a mismatch
      if (n >= 50) begin
         bad_count++;
         $display("ERROR pready expected 1 seen %b", pready);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   // random setup of port p, then edge events, masking and deactivation
   task automatic port_test(input int p);
      logic [7:0] m, ix, dr, pl, d;
      m = p ? 8'h1f : 8'hff;
      ix = DGP_IDX_DIR1 + 8'(4 * p);
      dr = 8'($random(seed)) | 8'h01; // pin 0 kept an input
      pl = 8'($random(seed));
      d = 8'($random(seed));
      brd[p] <= 8'($random(seed));
      apb(1'b1, ix, dr);
      apb(1'b1, ix + 8'h2, pl);
      apb(1'b1, ix + 8'h1, d);
      repeat (4) @(posedge sys_clk);
      chk("oe", {24'h0, dr & m}, p ? {27'h0, oeN2} : {24'h0, oeN1});
      chk("drive", {24'h0, (d ^ pl) & ~dr & m}, {24'h0, (p ? {3'h0, out2} : out1) & ~dr});
      apb(1'b0, ix + 8'h1, 8'h0);
      chk("data", {24'h0, ((d & ~dr) | ((brd[p] ^ pl) & dr)) & m}, rdv);
      apb(1'b0, ix + 8'h3, 8'h0);
      apb(1'b1, DGP_IDX_MSK1 + 8'(p), 8'h01);
      apb(1'b1, ix + 8'h3, 8'hff); // status ignores writes
      for (int k = 0; k < 2; k++) begin
         brd[p][0] <= ~brd[p][0];
         repeat (5) @(posedge sys_clk);
         chk("irq", 32'(k == 0), {31'h0, irq});
         apb(1'b0, ix + 8'h3, 8'h0);
         chk("status", 32'h1, rdv);
         chk("irq clear", 32'h0, {31'h0, irq});
         apb(1'b1, DGP_IDX_MSK1 + 8'(p), 8'h00);
      end
      apb(1'b1, DGP_IDX_ACT, p ? 8'h01 : 8'h02);
      chk("inactive", {24'h0, m}, p ? {27'h0, oeN2} : {24'h0, oeN1});
      apb(1'b1, DGP_IDX_ACT, 8'h03);
   endtask : port_test
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      brd[0] = 8'h00;
      brd[1] = 8'h00;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      // reset values of direction, data, polarity, status, mask
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            apb(1'b0, DGP_IDX_DIR1 + 8'(4 * p + k), 8'h0);
            chk("reset", k == 0 ? (p ? 32'h1f : 32'hff) : 32'h0, rdv);
         end
         apb(1'b0, DGP_IDX_MSK1 + 8'(p), 8'h0);
         chk("mask", 32'h0, rdv);
      end
      apb(1'b0, DGP_IDX_ACT, 8'h0);
      chk("act", 32'h3, rdv);
      apb(1'b0, 8'hff, 8'h0);
      chk("unmapped", 32'h1, {31'h0, errv});
      for (int i = 0; i < 6; i++) port_test(i % 2);
      complete_run();
   end
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
endmodule : tb_dual_gpio_port_bank
`default_nettype wire
